// *** hw/memmap_bank.sv ***
/*
  Data-memory map, system registers and code-option decode of a small
  8-bit core. Assumes the core drives a plain bus synchronous to CLOCK,
  code options are static straps, supply comparators arrive synchronous.
*/
`timescale 1ns/1ps

// Summary of operation
// - bank 0: 00h-7Fh general RAM, 80h-FFh system registers
// - bank 15 bytes 00h-1Fh are display segment memory
// - RC oscillator option frees crystal output pin as port 1 bit 2
// - always-on watchdog keeps counting in power-down and green modes
// - enabled watchdog is held cleared in low-power modes; disabled never acts
// - high-clock instruction cycle is oscillator divided by 1, 2, 4 or 8
// - noise filter on requires divider of 4 or more
// - divider only in high-clock mode; slow mode divides by four
// - reset pin option: external reset or input-only port 0 bit 2
// - security option blocks program ROM readout
// - lowest level resets below 2.0 V, no indicator flag
// - middle level resets below 2.0 V, flags supply below 2.4 V
// - highest level resets below 2.4 V, flags supply below 3.6 V
// - first indirect window accesses RAM at high/low pointer
// - second indirect window uses lookup pair, which also feeds ROM
// - eight stack levels of low and high bytes plus stack pointer
// - timer-0 reload buffer holds the auto-reload value
// - edge select register picks port 0 bit 0 active edge
// - port-1 wakeup register selects wake-capable pins
// - bank select register picks active data bank
module memmap_bank
  import memmap_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire bus_req_type BUS,
  input  wire options_type OPTIONS,
  input  wire logic        SLOW_MODE,
  input  wire logic        LOW_POWER,
  input  wire logic        HOSC_TICK,
  input  wire logic        LOSC_TICK,
  input  wire logic        SUPPLY_BELOW_2V0,
  input  wire logic        SUPPLY_BELOW_2V4,
  input  wire logic        SUPPLY_BELOW_3V6,
  input  wire logic        ROM_READ_REQ,
  output logic [7:0]       RDATA,
  output logic             CPU_TICK,
  output logic             CRYSTAL_OUTPUT_PIN_IS_GPIO,
  output logic             RESET_PIN_IS_GPIO,
  output logic             ROM_READ_BLOCK,
  output logic             LV_RESET,
  output logic             WDOG_TIMEOUT,
  output logic             OPTION_ERROR,
  output logic [15:0]      ROM_LOOKUP_ADDR,
  output logic [7:0]       T0_RELOAD,
  output logic [7:0]       EDGE_SELECT,
  output logic [7:0]       P1_WAKE_MASK
);

  logic [7:0] gp_ram_r   [GP_BYTES];
  logic [7:0] disp_ram_r [DISP_BYTES];
  logic [7:0] stack_r    [2*STACK_LEVELS];
  logic [7:0] ptr_low_r;
  logic [7:0] ptr_high_r;
  logic [7:0] lk_buf_r;
  logic [7:0] lk_low_r;
  logic [7:0] lk_mid_r;
  logic [7:0] flags_r;
  logic [7:0] bank_r;
  logic [7:0] reload_r;
  logic [7:0] edge_r;
  logic [7:0] wake_r;
  logic [7:0] sp_r;
  logic [7:0] ptr_low_nxt;
  logic [7:0] ptr_high_nxt;
  logic [7:0] lk_buf_nxt;
  logic [7:0] lk_low_nxt;
  logic [7:0] lk_mid_nxt;
  logic [7:0] flags_nxt;
  logic [7:0] bank_nxt;
  logic [7:0] reload_nxt;
  logic [7:0] edge_nxt;
  logic [7:0] wake_nxt;
  logic [7:0] sp_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] wdog_cnt_r;
  logic [7:0] wdog_cnt_nxt;
  logic [2:0] div_cnt_r;
  logic [2:0] div_cnt_nxt;
  logic       tick_nxt;
  logic       wdog_nxt;
  logic       lvr_nxt;
  logic       err_nxt;
  logic       rom_blk_nxt;
  logic       crystal_output_pin_nxt;
  logic       rpin_nxt;
  logic [7:0] eff_addr;
  logic [3:0] eff_bank;
  logic       wdog_run;
  logic       wdog_clr;
  logic       src_tick;
  logic       wr_gp;
  logic       wr_disp;
  logic       wr_stack;
  logic [2:0] div_mask;

  // indirect windows redirect to the RAM byte named by the pointer pair (window A) or the lookup pair (window B)
  always_comb begin
    eff_addr = BUS.addr;
    eff_bank = bank_r[3:0];
    if (BUS.addr == OFF_WIN_A) begin
      eff_addr = ptr_low_r;
      eff_bank = ptr_high_r[3:0];
    end else if (BUS.addr == OFF_WIN_B) begin
      eff_addr = lk_low_r;
      eff_bank = lk_mid_r[3:0];
    end
  end

  // registers write path
  always_comb begin
    ptr_low_nxt  = ptr_low_r;
    ptr_high_nxt = ptr_high_r;
    lk_buf_nxt   = lk_buf_r;
    lk_low_nxt   = lk_low_r;
    lk_mid_nxt   = lk_mid_r;
    bank_nxt     = bank_r;
    reload_nxt   = reload_r;
    edge_nxt     = edge_r;
    wake_nxt     = wake_r;
    sp_nxt       = sp_r;
    flags_nxt    = flags_r;
    if (BUS.wr) begin
      case (BUS.addr)
        OFF_PTR_LOW:    ptr_low_nxt  = BUS.wdata;
        OFF_PTR_HIGH:   ptr_high_nxt = BUS.wdata;
        OFF_LOOKUP_BUF: lk_buf_nxt   = BUS.wdata;
        OFF_LOOKUP_LOW: lk_low_nxt   = BUS.wdata;
        OFF_LOOKUP_MID: lk_mid_nxt   = BUS.wdata;
        OFF_PAGE_FLAGS: flags_nxt    = BUS.wdata;
        OFF_BANK_SEL:   bank_nxt     = BUS.wdata & BANK_SEL_MASK;
        OFF_T0_RELOAD:  reload_nxt   = BUS.wdata;
        OFF_EDGE_SEL:   edge_nxt     = BUS.wdata;
        OFF_P1_WAKE:    wake_nxt     = BUS.wdata;
        OFF_STACK_PTR:  sp_nxt       = BUS.wdata;
        default:        ;
      endcase
    end
    // supply flags are hardware driven; software writes cannot hold them
    flags_nxt[FLAG_LOW_MID_BIT] = (OPTIONS.lvl == LV_MID) && SUPPLY_BELOW_2V4;
    flags_nxt[FLAG_LOW_HI_BIT]  = (OPTIONS.lvl == LV_HIGH) && SUPPLY_BELOW_3V6;
  end

  // memories: general RAM, display RAM, stack rows
  // one shared decode; ram targets win over the stack rows
  always_comb begin
    wr_disp  = BUS.wr && eff_bank == BANK_DISPLAY && eff_addr <= DISP_LAST;
    wr_gp    = BUS.wr && eff_bank == 4'h0 && eff_addr < SYSREG_BASE;
    wr_stack = BUS.wr && !wr_disp && !wr_gp && BUS.addr >= OFF_STACK_BASE;
  end

  for (genvar g = 0; g < GP_BYTES; g++) begin : g_gp_ram
    logic [7:0] byte_nxt;
    always_comb begin
      byte_nxt = gp_ram_r[g];
      if (wr_gp && eff_addr[6:0] == 7'(g)) byte_nxt = BUS.wdata;
    end
    always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
        gp_ram_r[g] <= RESET_BYTE;
      end else begin
        gp_ram_r[g] <= byte_nxt;
      end
    end
  end : g_gp_ram

  for (genvar g = 0; g < DISP_BYTES; g++) begin : g_disp_ram
    logic [7:0] byte_nxt;
    always_comb begin
      byte_nxt = disp_ram_r[g];
      if (wr_disp && eff_addr[4:0] == 5'(g)) byte_nxt = BUS.wdata;
    end
    always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
        disp_ram_r[g] <= RESET_BYTE;
      end else begin
        disp_ram_r[g] <= byte_nxt;
      end
    end
  end : g_disp_ram

  for (genvar g = 0; g < 2*STACK_LEVELS; g++) begin : g_stack
    logic [7:0] byte_nxt;
    always_comb begin
      byte_nxt = stack_r[g];
      if (wr_stack && BUS.addr[3:0] == 4'(g)) byte_nxt = BUS.wdata;
    end
    always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
        stack_r[g] <= RESET_BYTE;
      end else begin
        stack_r[g] <= byte_nxt;
      end
    end
  end : g_stack

  // read path, one cycle latency
  always_comb begin
    rdata_nxt = RESET_BYTE;
    if (BUS.rd) begin
      if (eff_bank == BANK_DISPLAY && eff_addr <= DISP_LAST) begin
        rdata_nxt = disp_ram_r[eff_addr[4:0]];
      end else if (eff_bank == 4'h0 && eff_addr < SYSREG_BASE) begin
        rdata_nxt = gp_ram_r[eff_addr[6:0]];
      end else if (BUS.addr >= OFF_STACK_BASE) begin
        rdata_nxt = stack_r[BUS.addr[3:0]];
      end else begin
        case (BUS.addr)
          OFF_PTR_LOW:    rdata_nxt = ptr_low_r;
          OFF_PTR_HIGH:   rdata_nxt = ptr_high_r;
          OFF_LOOKUP_BUF: rdata_nxt = lk_buf_r;
          OFF_LOOKUP_LOW: rdata_nxt = lk_low_r;
          OFF_LOOKUP_MID: rdata_nxt = lk_mid_r;
          OFF_PAGE_FLAGS: rdata_nxt = flags_r;
          OFF_BANK_SEL:   rdata_nxt = bank_r;
          OFF_T0_RELOAD:  rdata_nxt = reload_r;
          OFF_EDGE_SEL:   rdata_nxt = edge_r;
          OFF_P1_WAKE:    rdata_nxt = wake_r;
          OFF_STACK_PTR:  rdata_nxt = sp_r;
          default:        rdata_nxt = RESET_BYTE;
        endcase
      end
    end
  end

  // instruction clock divider; filter forces at least divide by four
  always_comb begin
    case (OPTIONS.div)
      DIV_1:   div_mask = 3'h0;
      DIV_2:   div_mask = 3'h1;
      DIV_4:   div_mask = 3'h3;
      DIV_8:   div_mask = 3'h7;
      default: div_mask = 3'h0;
    endcase
    err_nxt = OPTIONS.filter_on && (OPTIONS.div == DIV_1 || OPTIONS.div == DIV_2);
    if (OPTIONS.filter_on && div_mask < 3'h3) div_mask = 3'h3;
    if (SLOW_MODE) div_mask = 3'h3;
    src_tick    = SLOW_MODE ? LOSC_TICK : HOSC_TICK;
    div_cnt_nxt = div_cnt_r;
    tick_nxt    = 1'b0;
    if (src_tick) begin
      if ((div_cnt_r & div_mask) == div_mask) begin
        div_cnt_nxt = DIV_CNT_ZERO;
        tick_nxt    = 1'b1;
      end else begin
        div_cnt_nxt = div_cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_cnt_r <= DIV_CNT_ZERO;
      CPU_TICK  <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      CPU_TICK  <= tick_nxt;
    end
  end

  // watchdog: simple counter, cleared by key write to its register
  always_comb begin
    wdog_clr = BUS.wr && BUS.addr == OFF_WDOG_CLEAR && BUS.wdata == WDOG_CLEAR_KEY;
    case (OPTIONS.wdog)
      WD_ALWAYS:  wdog_run = 1'b1;
      WD_ENABLE:  wdog_run = !LOW_POWER;
      WD_DISABLE: wdog_run = 1'b0;
      default:    wdog_run = 1'b0;
    endcase
    wdog_cnt_nxt = wdog_cnt_r;
    if (wdog_clr || !wdog_run) wdog_cnt_nxt = RESET_BYTE;
    else if (tick_nxt && wdog_cnt_r != WDOG_LIMIT) wdog_cnt_nxt = wdog_cnt_r + 8'h01;
    wdog_nxt    = wdog_run && wdog_cnt_r == WDOG_LIMIT;
    lvr_nxt     = (OPTIONS.lvl == LV_HIGH) ? SUPPLY_BELOW_2V4 : SUPPLY_BELOW_2V0;
    rom_blk_nxt = OPTIONS.secure && ROM_READ_REQ;
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      wdog_cnt_r   <= RESET_BYTE;
      WDOG_TIMEOUT <= 1'b0;
    end else begin
      wdog_cnt_r   <= wdog_cnt_nxt;
      WDOG_TIMEOUT <= wdog_nxt;
    end
  end

  // straps decoded here, flopped below, so the pins never glitch
  always_comb begin
    crystal_output_pin_nxt = OPTIONS.hiclk == OSC_RC;
    rpin_nxt = !OPTIONS.reset_pin_is_reset;
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ptr_low_r  <= RESET_BYTE;
      ptr_high_r <= RESET_BYTE;
      lk_buf_r   <= RESET_BYTE;
      lk_low_r   <= RESET_BYTE;
      lk_mid_r   <= RESET_BYTE;
      flags_r    <= RESET_BYTE;
      bank_r     <= RESET_BYTE;
      reload_r   <= RESET_BYTE;
      edge_r     <= RESET_BYTE;
      wake_r     <= RESET_BYTE;
      sp_r       <= RESET_BYTE;
      RDATA      <= RESET_BYTE;
      LV_RESET   <= 1'b0;
      OPTION_ERROR <= 1'b0;
      ROM_READ_BLOCK <= 1'b0;
      CRYSTAL_OUTPUT_PIN_IS_GPIO <= 1'b0;
      RESET_PIN_IS_GPIO <= 1'b0;
      ROM_LOOKUP_ADDR <= 16'h0000;
      T0_RELOAD  <= RESET_BYTE;
      EDGE_SELECT <= RESET_BYTE;
      P1_WAKE_MASK <= RESET_BYTE;
    end else begin
      ptr_low_r  <= ptr_low_nxt;
      ptr_high_r <= ptr_high_nxt;
      lk_buf_r   <= lk_buf_nxt;
      lk_low_r   <= lk_low_nxt;
      lk_mid_r   <= lk_mid_nxt;
      flags_r    <= flags_nxt;
      bank_r     <= bank_nxt;
      reload_r   <= reload_nxt;
      edge_r     <= edge_nxt;
      wake_r     <= wake_nxt;
      sp_r       <= sp_nxt;
      RDATA      <= rdata_nxt;
      LV_RESET   <= lvr_nxt;
      OPTION_ERROR <= err_nxt;
      ROM_READ_BLOCK <= rom_blk_nxt;
      CRYSTAL_OUTPUT_PIN_IS_GPIO <= crystal_output_pin_nxt;
      RESET_PIN_IS_GPIO <= rpin_nxt;
      ROM_LOOKUP_ADDR <= {lk_mid_nxt, lk_low_nxt};
      T0_RELOAD  <= reload_nxt;
      EDGE_SELECT <= edge_nxt;
      P1_WAKE_MASK <= wake_nxt;
    end
  end

endmodule : memmap_bank

// *** hw/memmap_pkg.sv ***
/*
  Package for the data-memory map and code-option block: register
  offsets, code-option encodings, reset values and the carrier structs.
  Assumes one 8-bit core data bus with one-cycle read latency.
*/
package memmap_pkg;

  localparam logic [7:0] SYSREG_BASE      = 8'h80;
  localparam logic [7:0] DISP_LAST        = 8'h1F;
  localparam logic [3:0] BANK_DISPLAY     = 4'hF;
  localparam int         GP_BYTES         = 128;
  localparam int         DISP_BYTES       = 32;

  localparam logic [7:0] OFF_PTR_LOW      = 8'h80;
  localparam logic [7:0] OFF_PTR_HIGH     = 8'h81;
  localparam logic [7:0] OFF_LOOKUP_BUF   = 8'h82;
  localparam logic [7:0] OFF_LOOKUP_LOW   = 8'h83;
  localparam logic [7:0] OFF_LOOKUP_MID   = 8'h84;
  localparam logic [7:0] OFF_PAGE_FLAGS   = 8'h86;
  localparam logic [7:0] OFF_BANK_SEL     = 8'h87;
  localparam logic [7:0] OFF_EDGE_SEL     = 8'hBF;
  localparam logic [7:0] OFF_P1_WAKE      = 8'hC0;
  localparam logic [7:0] OFF_WDOG_CLEAR   = 8'hCC;
  localparam logic [7:0] OFF_T0_RELOAD    = 8'hCD;
  localparam logic [7:0] OFF_STACK_PTR    = 8'hDF;
  localparam logic [7:0] OFF_WIN_A        = 8'hE6;
  localparam logic [7:0] OFF_WIN_B        = 8'hE7;
  localparam logic [7:0] OFF_STACK_BASE   = 8'hF0;
  localparam int         STACK_LEVELS     = 8;

  localparam int         FLAG_LOW_MID_BIT = 4;
  localparam int         FLAG_LOW_HI_BIT  = 5;
  localparam logic [7:0] BANK_SEL_MASK    = 8'h0F;
  localparam logic [7:0] WDOG_CLEAR_KEY   = 8'h5A;
  localparam logic [7:0] RESET_BYTE       = 8'h00;
  localparam logic [7:0] WDOG_LIMIT       = 8'hFF;

  typedef enum logic [1:0] {OSC_RC, OSC_XTAL_HI, OSC_XTAL_STD} hiclk_opt_type;
  typedef enum logic [1:0] {WD_ALWAYS, WD_ENABLE, WD_DISABLE} wdog_opt_type;
  typedef enum logic [1:0] {DIV_1, DIV_2, DIV_4, DIV_8} div_opt_type;
  typedef enum logic [1:0] {LV_LOW, LV_MID, LV_HIGH} lvl_opt_type;

  typedef struct packed {
    hiclk_opt_type hiclk;
    wdog_opt_type  wdog;
    div_opt_type   div;
    logic          filter_on;
    logic          reset_pin_is_reset;
    logic          secure;
    lvl_opt_type   lvl;
  } options_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

  localparam logic [2:0] DIV_CNT_ZERO = 3'h0;

endpackage : memmap_pkg

// *** tb/memmap_props.sv ***
/*
  Port-level properties of memmap_bank, bound to it below.
  Assumes one clock, static code options and an async low reset.
*/
`timescale 1ns/1ps
module memmap_props
  import memmap_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RESET_N,
  input wire bus_req_type BUS,
  input wire options_type OPTIONS,
  input wire logic        LOW_POWER,
  input wire logic        SUPPLY_BELOW_2V0,
  input wire logic        SUPPLY_BELOW_2V4,
  input wire logic        ROM_READ_REQ,
  input wire logic [7:0]  RDATA,
  input wire logic        CRYSTAL_OUTPUT_PIN_IS_GPIO,
  input wire logic        RESET_PIN_IS_GPIO,
  input wire logic        ROM_READ_BLOCK,
  input wire logic        LV_RESET,
  input wire logic        WDOG_TIMEOUT,
  input wire logic        OPTION_ERROR,
  input wire logic [7:0]  T0_RELOAD
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // option outputs lag their straps by one register
  a_crystal_pin_use: assert property ($past(RESET_N) |->
    CRYSTAL_OUTPUT_PIN_IS_GPIO == $past(OPTIONS.hiclk == OSC_RC)) else $error("crystal pin use wrong");
  a_reset_pin_use: assert property ($past(RESET_N) |->
    RESET_PIN_IS_GPIO == $past(!OPTIONS.reset_pin_is_reset)) else $error("reset pin wrong");
  a_rom_guard: assert property ($past(RESET_N) |->
    ROM_READ_BLOCK == $past(OPTIONS.secure && ROM_READ_REQ)) else $error("rom guard wrong");
  a_low_volt_reset: assert property ($past(RESET_N) |-> LV_RESET ==
    $past(OPTIONS.lvl == LV_HIGH ? SUPPLY_BELOW_2V4 : SUPPLY_BELOW_2V0))
    else $error("low supply reset wrong");
  a_filter_divider: assert property ($past(RESET_N) |-> OPTION_ERROR ==
    $past(OPTIONS.filter_on && OPTIONS.div inside {DIV_1, DIV_2}))
    else $error("filter divider check wrong");
  a_unmapped_zero: assert property (BUS.rd && BUS.addr inside {8'h85, 8'h88} |=>
    RDATA == 8'h00) else $error("unmapped read not zero");
  // two cycles of grace: the timeout flag is registered
  a_wdog_disabled: assert property ((OPTIONS.wdog == WD_DISABLE)[*2] |->
    !WDOG_TIMEOUT) else $error("disabled watchdog fired");
  a_wdog_halted: assert property ((LOW_POWER && OPTIONS.wdog == WD_ENABLE)[*3] |->
    !WDOG_TIMEOUT) else $error("halted watchdog fired");
  a_reload_write: assert property (BUS.wr && BUS.addr == OFF_T0_RELOAD |=>
    T0_RELOAD == $past(BUS.wdata)) else $error("reload buffer not written");
  c_read: cover property (BUS.rd);
  c_timeout: cover property (WDOG_TIMEOUT);
  c_option_error: cover property (OPTION_ERROR);
endmodule : memmap_props

bind memmap_bank memmap_props u_props (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .BUS(BUS), .OPTIONS(OPTIONS), .LOW_POWER(LOW_POWER),
  .SUPPLY_BELOW_2V0(SUPPLY_BELOW_2V0), .SUPPLY_BELOW_2V4(SUPPLY_BELOW_2V4),
  .ROM_READ_REQ(ROM_READ_REQ), .RDATA(RDATA), .CRYSTAL_OUTPUT_PIN_IS_GPIO(CRYSTAL_OUTPUT_PIN_IS_GPIO),
  .RESET_PIN_IS_GPIO(RESET_PIN_IS_GPIO), .ROM_READ_BLOCK(ROM_READ_BLOCK),
  .LV_RESET(LV_RESET), .WDOG_TIMEOUT(WDOG_TIMEOUT), .OPTION_ERROR(OPTION_ERROR),
  .T0_RELOAD(T0_RELOAD)
);

// *** tb/testbench.sv ***
/*
  Self-checking bench for memmap_bank: map, windows, options, watchdog.
  Assumes the checker file is compiled with it; reads queue their results.
*/
`timescale 1ns/1ps
module testbench
  import memmap_pkg::*;
;
  logic        clock, reset_n, slow, lp, htick, ltick, b20, b24, b36, romreq, rd_d;
  logic        tick, crystal_output_pin_gpio, rpin_gpio, rom_block, lv_reset, wdog_to, opt_err;
  logic [7:0]  rdata, t0_rel, edge_sel, wake, d;
  logic [15:0] lookup;
  bus_req_type bus;
  options_type opt;
  logic [7:0]  exp_q[$], msk_q[$];
  int          err_total, checks;

  memmap_bank DUT (.CLOCK(clock), .RESET_N(reset_n), .BUS(bus), .OPTIONS(opt),
    .SLOW_MODE(slow), .LOW_POWER(lp), .HOSC_TICK(htick), .LOSC_TICK(ltick),
    .SUPPLY_BELOW_2V0(b20), .SUPPLY_BELOW_2V4(b24), .SUPPLY_BELOW_3V6(b36),
    .ROM_READ_REQ(romreq), .RDATA(rdata), .CPU_TICK(tick), .CRYSTAL_OUTPUT_PIN_IS_GPIO(crystal_output_pin_gpio),
    .RESET_PIN_IS_GPIO(rpin_gpio), .ROM_READ_BLOCK(rom_block), .LV_RESET(lv_reset),
    .WDOG_TIMEOUT(wdog_to), .OPTION_ERROR(opt_err), .ROM_LOOKUP_ADDR(lookup),
    .T0_RELOAD(t0_rel), .EDGE_SELECT(edge_sel), .P1_WAKE_MASK(wake));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic compare(input string what, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask : compare

  // strobe stays up between calls so back-to-back ops never double-drive
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] dv,
                    input logic [7:0] m);
    bus <= '{a, dv, w, !w};
    if (!w) begin
      exp_q.push_back(dv);
      msk_q.push_back(m);
    end
    @(posedge clock);
  endtask : op

  task automatic idle();
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    @(posedge clock);
  endtask : idle

  // first interval after a divider change may be a leftover phase
  task automatic per(input int p);
    int n;
    n = 0;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (tick !== 1'b1 && n < 20);
    end
    compare("tick period", 16'(p), 16'(n));
  endtask : per

  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clock) begin
    rd_d <= bus.rd && reset_n;
    if (rd_d) begin
      compare("read data", {8'h00, exp_q[0] & msk_q[0]}, {8'h00, rdata & msk_q[0]});
      exp_q.delete(0);
      msk_q.delete(0);
    end
  end

  initial begin
    repeat (6000) @(posedge clock);
    err_total++;
    end_of_test();
  end

  initial begin
    {reset_n, slow, lp, htick, ltick, b20, b24, b36, romreq} = '0;
    bus = '0;
    opt = '{OSC_XTAL_STD, WD_DISABLE, DIV_4, 1'b0, 1'b1, 1'b0, LV_LOW};
    void'($urandom(88));
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    op(0, OFF_BANK_SEL, RESET_BYTE, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      op(1, 8'(i * 51 + 4), d, 0);
      op(0, 8'(i * 51 + 4), (8'(i * 51 + 4) < SYSREG_BASE) ? d : 8'h00, 8'hFF);
    end
    op(1, 8'h85, 8'hFF, 0);
    op(0, 8'h85, 8'h00, 8'hFF);
    op(0, 8'h88, 8'h00, 8'hFF);
    op(1, 8'h00, 8'h11, 0);
    op(1, OFF_BANK_SEL, 8'hFF, 0);
    op(0, OFF_BANK_SEL, BANK_SEL_MASK, 8'hFF);
    op(1, 8'h00, 8'h22, 0);
    op(1, DISP_LAST, 8'h33, 0);
    op(0, 8'h00, 8'h22, 8'hFF);
    op(0, DISP_LAST, 8'h33, 8'hFF);
    op(1, OFF_BANK_SEL, 8'h00, 0);
    op(0, 8'h00, 8'h11, 8'hFF);
    op(1, OFF_PTR_HIGH, 8'h0F, 0);
    op(1, OFF_PTR_LOW, 8'h05, 0);
    op(1, OFF_WIN_A, 8'h44, 0);
    op(1, OFF_BANK_SEL, 8'h0F, 0);
    op(0, 8'h05, 8'h44, 8'hFF);
    op(1, OFF_BANK_SEL, 8'h00, 0);
    op(1, OFF_LOOKUP_MID, 8'h00, 0);
    op(1, OFF_LOOKUP_LOW, 8'h12, 0);
    op(1, 8'h12, 8'h55, 0);
    op(0, OFF_WIN_B, 8'h55, 8'hFF);
    op(1, OFF_WIN_B, 8'h66, 0);
    op(0, 8'h12, 8'h66, 8'hFF);
    compare("lookup address", 16'h0012, lookup);
    for (int i = 0; i < 2 * STACK_LEVELS; i++) op(1, OFF_STACK_BASE + 8'(i), 8'(~i), 0);
    for (int i = 0; i < 2 * STACK_LEVELS; i++)
      op(0, OFF_STACK_BASE + 8'(i), 8'(~i), 8'hFF);
    d = 8'($urandom);
    op(1, OFF_STACK_PTR, d, 0);
    op(1, OFF_T0_RELOAD, d, 0);
    op(1, OFF_EDGE_SEL, ~d, 0);
    op(1, OFF_P1_WAKE, d & 8'h7F, 0);
    op(0, OFF_STACK_PTR, d, 8'hFF);
    idle();
    compare("reload buffer", {8'h00, d}, {8'h00, t0_rel});
    compare("edge select", {8'h00, ~d}, {8'h00, edge_sel});
    compare("wake mask", {8'h00, d & 8'h7F}, {8'h00, wake});
    {b20, b24, b36} <= 3'b111;
    for (int l = 0; l < 3; l++) begin
      opt.lvl <= lvl_opt_type'(l);
      idle();
      op(0, OFF_PAGE_FLAGS, {2'b00, l == 2, l == 1, 4'h0}, 8'h30);
    end
    idle();
    htick <= 1'b1;
    ltick <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      opt.hiclk <= hiclk_opt_type'(k % 3);
      opt.div <= div_opt_type'(k == 5 ? 3 : k % 4);
      opt.filter_on <= k > 3;
      opt.secure <= k[0];
      opt.reset_pin_is_reset <= k[1];
      romreq <= k[2];
      slow <= k == 5;
      htick <= k != 5;
      {b20, b24, b36} <= 3'($urandom);
      repeat (2) @(posedge clock);
      compare("crystal pin", {15'h0, k % 3 == 0}, {15'h0, crystal_output_pin_gpio});
      compare("rom guard", {15'h0, k == 5}, {15'h0, rom_block});
      per(k == 5 ? 4 : (k == 4 ? 4 : 1 << (k % 4)));
    end
    opt.div <= DIV_1;
    htick <= 1'b1;
    opt.filter_on <= 1'b0;
    slow <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      opt.wdog <= wdog_opt_type'(k == 3 ? 1 : k);
      lp <= k < 3;
      op(1, OFF_WDOG_CLEAR, WDOG_CLEAR_KEY, 0);
      idle();
      repeat (300) @(posedge clock);
      compare("watchdog", {15'h0, k == 0 || k == 3}, {15'h0, wdog_to});
    end
    op(1, OFF_WDOG_CLEAR, WDOG_CLEAR_KEY, 0);
    repeat (2) idle();
    compare("watchdog cleared", 16'h0000, {15'h0, wdog_to});
    end_of_test();
  end
endmodule : testbench
